// file: src/acr_pkg.sv
// constants, layouts and bus types for the calibration / checksum block
//==============================================================
// Summary of operation
// [R1] sinc3 decimator, response cube of (1-z^-N)/(N(1-z^-1)), N 128..1024
// [R2] each channel result has its stored 24-bit offset subtracted
// [R3] each channel keeps its own offset in an upper and a lower register
// [R4] offset is signed two's complement, same format as the data
// [R5] each channel result is multiplied by its own 24-bit gain
// [R6] gain unsigned, 000000h zero, 800000h unity, steps up to just below two
// [R7] offset and gain are always applied, no bypass
// [R8] after any reset offsets are zero and gains are unity
// [R9] host keeps coefficients itself and rewrites them after each reset
// [R10] image checksum runs only while its mode enable bit is set
// [R11] checksum covers 02h..12h, MSB of 02h first, LSB of 12h last
// [R12] mode type bit picks CCITT or ANSI CRC-16 polynomial
// [R13] every checksum pass starts from the all-ones seed
// [R14] checksum is 16 bits, readable in its own register
// [R15] one image bit per clock, continuous, each result compared to last
// [R16] a changed checksum sets the image-changed status flag
// [R17] flag clears on status read or on a no-operation status reply
// [R18] power-on, pin and command resets restore all register defaults
// [R19] conversions start by themselves after reset, no start command
// [R20] bus traffic ignored until ready line rises after reset
// [R21] ready line rises right after the power-on settling interval
// [R22] pin held low past minimum width resets and holds until high
// [R23] offset first, gain second, result saturates to signed 24 bits
//==============================================================
package acr_pkg;

  // register word addresses
  localparam logic [5:0] A_STATUS   = 6'h01;
  localparam logic [5:0] A_MODE     = 6'h02;
  localparam logic [5:0] A_CLOCK    = 6'h03;
  localparam logic [5:0] A_CH_BASE  = 6'h04;
  localparam logic [5:0] A_CH_STEP  = 6'h04;
  localparam logic [5:0] A_IMG_LO   = 6'h02;
  localparam logic [5:0] A_IMG_HI   = 6'h12;
  localparam logic [5:0] A_CHECKSUM = 6'h13;
  localparam int         IMG_WORDS  = 17;
  localparam int         IMG_BITS   = 272;
  localparam int         WR_WORDS   = 10;

  // field positions
  localparam int MODE_CRC_EN   = 0;
  localparam int MODE_CRC_TYPE = 1;
  localparam int STAT_CHANGED  = 0;

  // reset values and write masks
  localparam logic [15:0] RST_MODE     = 16'h0000;
  localparam logic [15:0] RST_CLOCK    = 16'h0003;
  localparam logic [15:0] RST_OFS_HI   = 16'h0000;
  localparam logic [15:0] RST_OFS_LO   = 16'h0000;
  localparam logic [15:0] RST_GAIN_HI  = 16'h8000;
  localparam logic [15:0] RST_GAIN_LO  = 16'h0000;
  localparam logic [15:0] RST_CHECKSUM = 16'h0000;
  localparam logic [15:0] MASK_CFG     = 16'h0003;
  localparam logic [15:0] MASK_HI      = 16'hffff;
  localparam logic [15:0] MASK_LO      = 16'hff00;
  localparam logic [23:0] GAIN_UNITY   = 24'h800000;

  // checksum polynomials and seed
  localparam logic [15:0] CRC_SEED  = 16'hffff;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI  = 16'h8005;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_POR_NS      = 100000;
  localparam int T_RSTW_NS     = 2000;
  localparam int T_ACQ_NS      = 5000;
  localparam int POR_CYC  = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTW_CYC = (T_RSTW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC  = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] RDY_LOW_CYC = 3'h4;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } acr_bus_type;

  // calibrated sample pair
  typedef struct packed {
    logic             valid;
    logic [1:0][23:0] data;
  } acr_sample_type;

endpackage

// file: src/acr_top.sv
// calibration datapath, register image checksum and reset sequencing
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module acr_top #(
  parameter int POR_CYC  = acr_pkg::POR_CYC,
  parameter int RSTW_CYC = acr_pkg::RSTW_CYC,
  parameter int ACQ_CYC  = acr_pkg::ACQ_CYC
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // pins and serial-side events
  input  wire logic                 i_sync_reset_n,
  input  wire logic                 i_reset_cmd,
  input  wire logic                 i_null_status,
  output logic                      o_sample_ready_n,
  // modulator bitstreams, one bit per channel per clock
  input  wire logic [1:0]           i_mod_bits,
  output acr_pkg::acr_sample_type   o_sample,
  // register port
  input  wire acr_pkg::acr_bus_type i_bus,
  output logic [15:0]               o_rdata
);

  //==============================================================
  // parameter checks
  generate
    if (POR_CYC < 1 || POR_CYC > 65535 || RSTW_CYC < 1 ||
        RSTW_CYC > 65535 || ACQ_CYC < 1 || ACQ_CYC > 65535) begin : g_chk
      $error("acr_top: timing count out of range");
    end
  endgenerate

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  //==============================================================
  // reset sequencing
  logic        pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  logic [15:0] low_cnt_q;
  logic        soft_rst_q;
  logic [15:0] wait_q;
  logic        ready_q;
  logic        pin_hold;

  // three-stage pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= i_sync_reset_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // level accepted once the last two stages agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_lvl_q <= 1'b1;
    end else if (pin_s2_q == pin_s3_q) begin
      pin_lvl_q <= pin_s3_q;
    end
  end

  // low-time counter, saturating at the minimum width
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_q <= 16'h0000;
    end else if (pin_lvl_q) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'(RSTW_CYC)) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  assign pin_hold = (low_cnt_q == 16'(RSTW_CYC)) && !pin_lvl_q; // [R22]

  // internal reset from pin or command
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= pin_hold | i_reset_cmd; // [R18] [R22]
    end
  end

  // settle countdown, then the interface is ready
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 16'(POR_CYC); // [R21]
    end else if (soft_rst_q) begin
      wait_q <= 16'(ACQ_CYC);
    end else if (wait_q != 16'h0000) begin
      wait_q <= wait_q - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (wait_q == 16'h0000) && !soft_rst_q; // [R21]
    end
  end

  //==============================================================
  // register image 02h..12h
  logic [15:0] img_q [acr_pkg::IMG_WORDS];
  logic        acc_wr, acc_rd;
  logic [23:0] ofs_w  [2];
  logic [23:0] gain_w [2];
  logic        crc_en;
  logic [1:0]  osr_sel;

  assign acc_wr = i_bus.wr && ready_q; // [R20]
  assign acc_rd = i_bus.rd && ready_q; // [R20]

  function automatic logic [15:0] img_rst(input int i);
    if (i == 0) begin
      return acr_pkg::RST_MODE;
    end else if (i == 1) begin
      return acr_pkg::RST_CLOCK;
    end else if (i >= acr_pkg::WR_WORDS) begin
      return 16'h0000;
    end else if ((i - 2) % 4 == 0) begin
      return acr_pkg::RST_OFS_HI;
    end else if ((i - 2) % 4 == 1) begin
      return acr_pkg::RST_OFS_LO;
    end else if ((i - 2) % 4 == 2) begin
      return acr_pkg::RST_GAIN_HI;
    end
    return acr_pkg::RST_GAIN_LO;
  endfunction

  function automatic logic [15:0] img_mask(input int i);
    if (i < 2) begin
      return acr_pkg::MASK_CFG;
    end else if (i >= acr_pkg::WR_WORDS) begin
      return 16'h0000;
    end else if ((i - 2) % 2 == 0) begin
      return acr_pkg::MASK_HI;
    end
    return acr_pkg::MASK_LO;
  endfunction

  // one writable word per entry, reserved words stay zero
  generate
    for (genvar i = 0; i < acr_pkg::IMG_WORDS; i++) begin : g_img
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          img_q[i] <= img_rst(i); // [R8]
        end else if (soft_rst_q) begin
          img_q[i] <= img_rst(i); // [R18]
        end else if (acc_wr &&
                     i_bus.addr == acr_pkg::A_IMG_LO + 6'(i)) begin
          img_q[i] <= i_bus.wdata & img_mask(i);
        end
      end
    end
  endgenerate

  // per-channel coefficient fields
  generate
    for (genvar c = 0; c < 2; c++) begin : g_coef
      assign ofs_w[c]  = {img_q[2 + 4*c], img_q[3 + 4*c][15:8]}; // [R3]
      assign gain_w[c] = {img_q[4 + 4*c], img_q[5 + 4*c][15:8]}; // [R5]
    end
  endgenerate

  assign crc_en  = img_q[0][acr_pkg::MODE_CRC_EN];
  assign osr_sel = img_q[1][1:0];

  //==============================================================
  // image checksum engine
  logic [8:0]  idx_q;
  logic [15:0] crc_q, checksum_q, crc_nxt, poly;
  logic        have_prev_q, changed_q, crc_bit, last_bit;
  logic        crc_set, crc_clr;

  assign poly     = img_q[0][acr_pkg::MODE_CRC_TYPE] ?
                    acr_pkg::POLY_ANSI : acr_pkg::POLY_CCITT; // [R12]
  assign crc_bit  = img_q[idx_q[8:4]][4'hf - idx_q[3:0]]; // [R11]
  assign last_bit = (idx_q == 9'(acr_pkg::IMG_BITS - 1));
  assign crc_nxt  = {crc_q[14:0], 1'b0} ^
                    ((crc_q[15] ^ crc_bit) ? poly : 16'h0000);

  // one bit per clock, result kept after the final bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q       <= 9'h000;
      crc_q       <= acr_pkg::CRC_SEED;
      checksum_q  <= acr_pkg::RST_CHECKSUM;
      have_prev_q <= 1'b0;
    end else if (soft_rst_q) begin
      idx_q       <= 9'h000;
      crc_q       <= acr_pkg::CRC_SEED;
      checksum_q  <= acr_pkg::RST_CHECKSUM;
      have_prev_q <= 1'b0;
    end else if (crc_en) begin // [R10]
      if (last_bit) begin
        idx_q       <= 9'h000;
        crc_q       <= acr_pkg::CRC_SEED; // [R13]
        checksum_q  <= crc_nxt; // [R14]
        have_prev_q <= 1'b1;
      end else begin
        idx_q <= idx_q + 9'h001; // [R15]
        crc_q <= crc_nxt;
      end
    end
  end

  assign crc_set = crc_en && last_bit && have_prev_q &&
                   (crc_nxt != checksum_q); // [R15] [R16]
  assign crc_clr = (acc_rd && i_bus.addr == acr_pkg::A_STATUS) ||
                   i_null_status; // [R17]

  // sticky flag, a new change beats a clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      changed_q <= 1'b0;
    end else if (soft_rst_q) begin
      changed_q <= 1'b0;
    end else if (crc_set) begin
      changed_q <= 1'b1; // [R16]
    end else if (crc_clr) begin
      changed_q <= 1'b0; // [R17]
    end
  end

  //==============================================================
  // register read port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (!acc_rd) begin
      o_rdata <= 16'h0000;
    end else if (i_bus.addr == acr_pkg::A_STATUS) begin
      o_rdata <= {15'h0000, changed_q};
    end else if (i_bus.addr == acr_pkg::A_CHECKSUM) begin
      o_rdata <= checksum_q; // [R14]
    end else if (i_bus.addr >= acr_pkg::A_IMG_LO &&
                 i_bus.addr <= acr_pkg::A_IMG_HI) begin
      o_rdata <= img_q[5'(i_bus.addr - acr_pkg::A_IMG_LO)];
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  //==============================================================
  // sinc3 decimator, both channels
  logic [10:0] dec_q;
  logic [10:0] osr_n;
  logic        tick, raw_vld_q;
  logic [23:0] raw_q [2];

  function automatic logic [23:0] sat24(input logic signed [49:0] v);
    if (v > 50'sh7fffff) begin
      return 24'h7fffff;
    end else if (v < -50'sh800000) begin
      return 24'h800000;
    end
    return v[23:0];
  endfunction

  assign osr_n = 11'h080 << osr_sel;
  assign tick  = (dec_q == osr_n - 11'h001);

  // decimation counter runs from reset on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dec_q <= 11'h000;
    end else if (soft_rst_q || tick || dec_q >= osr_n) begin
      dec_q <= 11'h000; // [R19]
    end else begin
      dec_q <= dec_q + 11'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw_vld_q <= 1'b0;
    end else begin
      raw_vld_q <= tick && !soft_rst_q; // [R19]
    end
  end

  generate
    for (genvar c = 0; c < 2; c++) begin : g_sinc
      logic [31:0] int1_q, int2_q, int3_q, dl1_q, dl2_q, dl3_q;
      logic [31:0] cmb1, cmb2, cmb3, x;
      logic signed [49:0] scaled;

      assign x    = i_mod_bits[c] ? 32'h00000001 : 32'hffffffff;
      assign cmb1 = int3_q - dl1_q;
      assign cmb2 = cmb1 - dl2_q;
      assign cmb3 = cmb2 - dl3_q;
      // N^3 gain removed, full scale lands at 2^23
      assign scaled = ($signed({{18{cmb3[31]}}, cmb3}) <<< 2) >>>
                      (3 * osr_sel); // [R1]

      // integrators on every clock, combs at the decimated rate
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          int1_q <= 32'h00000000;
          int2_q <= 32'h00000000;
          int3_q <= 32'h00000000;
          dl1_q  <= 32'h00000000;
          dl2_q  <= 32'h00000000;
          dl3_q  <= 32'h00000000;
          raw_q[c] <= 24'h000000;
        end else if (soft_rst_q) begin
          int1_q <= 32'h00000000;
          int2_q <= 32'h00000000;
          int3_q <= 32'h00000000;
          dl1_q  <= 32'h00000000;
          dl2_q  <= 32'h00000000;
          dl3_q  <= 32'h00000000;
          raw_q[c] <= 24'h000000;
        end else begin
          int1_q <= int1_q + x; // [R1]
          int2_q <= int2_q + int1_q;
          int3_q <= int3_q + int2_q;
          if (tick) begin
            dl1_q    <= int3_q;
            dl2_q    <= cmb1;
            dl3_q    <= cmb2;
            raw_q[c] <= sat24(scaled);
          end
        end
      end
    end
  endgenerate

  //==============================================================
  // calibration, offset then gain, saturated
  logic [2:0]  rdy_cnt_q;
  logic [23:0] cal_w [2];

  generate
    for (genvar c = 0; c < 2; c++) begin : g_cal
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      assign diff = $signed({raw_q[c][23], raw_q[c]}) -
                    $signed({ofs_w[c][23], ofs_w[c]}); // [R2] [R4]
      assign prod = diff * $signed({1'b0, gain_w[c]}); // [R5] [R6]
      assign cal_w[c] = sat24(prod >>> 23); // [R23]
    end
  endgenerate

  // output stage, always through the correction
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= '0;
    end else begin
      o_sample.valid   <= raw_vld_q && !soft_rst_q;
      if (raw_vld_q) begin
        o_sample.data[0] <= cal_w[0]; // [R7]
        o_sample.data[1] <= cal_w[1]; // [R7]
      end
    end
  end

  // ready line: low until ready, then a short low per sample
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_cnt_q <= 3'h0;
    end else if (raw_vld_q && ready_q) begin
      rdy_cnt_q <= acr_pkg::RDY_LOW_CYC;
    end else if (rdy_cnt_q != 3'h0) begin
      rdy_cnt_q <= rdy_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_ready_n <= 1'b0;
    end else begin
      o_sample_ready_n <= ready_q && (rdy_cnt_q == 3'h0); // [R20] [R21]
    end
  end

  //==============================================================
  // assertions
  a_ofs_reset_zero: assert property ( // [R8]
    soft_rst_q |=> (ofs_w[0] == 24'h000000 && ofs_w[1] == 24'h000000))
    else $error("offset not zero after reset");

  a_gain_reset_unity: assert property ( // [R8]
    soft_rst_q |=> (gain_w[0] == acr_pkg::GAIN_UNITY &&
                    gain_w[1] == acr_pkg::GAIN_UNITY))
    else $error("gain not unity after reset");

  a_crc_seed_start: assert property ( // [R13]
    (crc_en && idx_q == 9'h000) |-> crc_q == acr_pkg::CRC_SEED)
    else $error("checksum pass not seeded");

  a_crc_idle_hold: assert property ( // [R10]
    (!crc_en && !soft_rst_q) |=> ($stable(idx_q) && $stable(checksum_q)))
    else $error("checksum moved while disabled");

  a_crc_bit_step: assert property ( // [R15]
    (crc_en && !last_bit && !soft_rst_q) |=>
      idx_q == $past(idx_q) + 9'h001)
    else $error("checksum not one bit per clock");

  a_flag_on_change: assert property ( // [R16]
    (crc_set && !soft_rst_q) |=> changed_q [*2] or (changed_q ##1 1'b1))
    else $error("changed flag not set");

  a_flag_clear_read: assert property ( // [R17]
    (crc_clr && !crc_set && !soft_rst_q) |=> !changed_q)
    else $error("changed flag not cleared");

  a_bus_ignored: assert property ( // [R20]
    (!ready_q && i_bus.wr && !soft_rst_q) |=>
      ($stable(img_q[0]) && $stable(img_q[2]) && $stable(img_q[4])))
    else $error("write taken before ready");

  a_pin_reset_hold: assert property ( // [R22]
    pin_hold |=> soft_rst_q ##1 !ready_q)
    else $error("pin reset not held");

  a_ready_rise: assert property ( // [R21]
    $rose(ready_q) |-> ($past(wait_q) == 16'h0000 && !$past(soft_rst_q)))
    else $error("ready rose before settle end");

  a_cal_unity: assert property ( // [R7]
    (raw_vld_q && !soft_rst_q && ofs_w[0] == 24'h000000 &&
     gain_w[0] == acr_pkg::GAIN_UNITY) |=>
      (o_sample.valid && o_sample.data[0] == $past(raw_q[0])))
    else $error("unity calibration altered sample");

  c_flag_set:   cover property (crc_set);
  c_sample_out: cover property (o_sample.valid && ready_q);
  c_pin_reset:  cover property (pin_hold ##[1:200] $rose(ready_q));

endmodule

// file: dv/acr_host_model.sv
// host-side model: master of the register port
`timescale 1ns/100ps
module acr_host_model (
  // clock
  input  wire logic                 i_clk,
  // device answers
  input  wire logic [15:0]          i_rdata,
  input  wire logic                 i_sample_ready_n,
  // register port request
  output acr_pkg::acr_bus_type      o_bus
);
  //==============================================================
  // bus cycles
  initial o_bus = '0;

  // one-cycle write strobe, then idle
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk) o_bus <= {1'b1, 1'b0, a, d};
    @(posedge i_clk) o_bus <= '0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_clk) o_bus <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk) o_bus <= '0;
    #1 d = i_rdata;
  endtask

  // hold off all traffic until the ready line rises
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(posedge i_clk);
      #1 ok = (i_sample_ready_n === 1'b1);
    end
  endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the calibration / checksum block
`timescale 1ns/100ps
module tb_top;
  logic                    clk;
  logic                    rst_n;
  logic                    sync_n;
  logic                    cmd;
  logic                    nul;
  logic [1:0]              mod;
  logic                    rdy_n;
  acr_pkg::acr_sample_type smp;
  acr_pkg::acr_bus_type    bus;
  logic [15:0]             rdata;
  logic [15:0]             img [2:18];
  logic [15:0]             v;
  logic [15:0]             e;
  logic                    ok;
  int                      failures;
  int                      n_checks;

  //==============================================================
  // clock and instances
  initial clk = 1'b0;
  always #50 clk = ~clk;

  acr_top #(.POR_CYC(20), .RSTW_CYC(4), .ACQ_CYC(10)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_sync_reset_n(sync_n),
    .i_reset_cmd(cmd), .i_null_status(nul), .o_sample_ready_n(rdy_n),
    .i_mod_bits(mod), .o_sample(smp), .i_bus(bus), .o_rdata(rdata));

  acr_host_model u_host (
    .i_clk(clk), .i_rdata(rdata), .i_sample_ready_n(rdy_n), .o_bus(bus));

  //==============================================================
  // helpers
  task automatic chk(input string n, input logic [23:0] x,
                     input logic [23:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [15:0] x);
    u_host.rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, x}, {8'h00, v});
  endtask

  // write mask of a word in the checksummed image
  function automatic logic [15:0] msk(input logic [5:0] a);
    if (a < 6'h04) return acr_pkg::MASK_CFG;
    if (a > 6'h0b) return 16'h0000;
    return a[0] ? acr_pkg::MASK_LO : acr_pkg::MASK_HI;
  endfunction

  // write and keep the shadow image in step
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    u_host.wr(a, d);
    if (a >= 6'h02 && a <= 6'h12) img[a] = d & msk(a);
  endtask

  task automatic coef(input int c, input logic [23:0] o,
                      input logic [23:0] g);
    logic [5:0] b;
    b = 6'(acr_pkg::A_CH_BASE + acr_pkg::A_CH_STEP * c);
    wreg(b, o[23:8]);
    wreg(b + 6'h01, {o[7:0], 8'h00});
    wreg(b + 6'h02, g[23:8]);
    wreg(b + 6'h03, {g[7:0], 8'h00});
  endtask

  task automatic reset_img();
    for (int w = 2; w <= 18; w++) img[w] = 16'h0000;
    img[2] = acr_pkg::RST_MODE;
    img[3] = acr_pkg::RST_CLOCK;
    img[6] = acr_pkg::RST_GAIN_HI;
    img[10] = acr_pkg::RST_GAIN_HI;
  endtask

  // msb-first shift-left checksum over the shadow image
  function automatic logic [15:0] crc(input logic [15:0] p);
    logic [15:0] r;
    r = acr_pkg::CRC_SEED;
    for (int w = 2; w <= 18; w++)
      for (int b = 15; b >= 0; b--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ img[w][b]) ? p : 16'h0000);
    return r;
  endfunction

  task automatic valids(input int n);
    int k;
    k = 0;
    for (int i = 0; i < 5000 && k < n; i++) begin
      @(posedge clk);
      #1 if (smp.valid === 1'b1) k++;
    end
    if (k < n) chk("sample valid", 24'h000001, 24'h000000);
  endtask

  task automatic dchk(input logic [23:0] x0, input logic [23:0] x1);
    valids(4); // fourth sample has a full filter window
    chk("ch0 data", x0, smp.data[0]);
    chk("ch1 data", x1, smp.data[1]);
  endtask

  task automatic passes();
    repeat (3 * acr_pkg::IMG_BITS + 20) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //==============================================================
  // watchdog
  initial begin
    #6000000;
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test();
  end

  //==============================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    sync_n = 1'b1;
    cmd = 1'b0;
    nul = 1'b0;
    mod = 2'b01;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reset_img();
    u_host.wr(6'h06, 16'h1234);
    u_host.rd(6'h06, v);
    chk("early read", 24'h000000, {8'h00, v});
    u_host.wait_ready(ok);
    chk("ready rise", 24'h000001, {23'h0, ok});
    for (int c = 0; c < 2; c++) begin
      rchk(6'(4 * c + 4), acr_pkg::RST_OFS_HI);
      rchk(6'(4 * c + 5), acr_pkg::RST_OFS_LO);
      rchk(6'(4 * c + 6), acr_pkg::RST_GAIN_HI);
      rchk(6'(4 * c + 7), acr_pkg::RST_GAIN_LO);
    end
    rchk(acr_pkg::A_CHECKSUM, acr_pkg::RST_CHECKSUM);
    rchk(6'h0c, 16'h0000);
    rchk(6'h20, 16'h0000);
    wreg(acr_pkg::A_CLOCK, 16'h0000);
    wreg(6'h05, 16'h01ab);
    rchk(6'h05, 16'h0100);
    wreg(6'h05, 16'h0000);
    dchk(24'h7fffff, 24'h800000);
    coef(0, 24'h100001, 24'h800000);
    coef(1, 24'hffffff, 24'h800000);
    dchk(24'h6ffffe, 24'h800001);
    wreg(acr_pkg::A_CLOCK, 16'h0002);
    coef(0, 24'h000000, 24'h400000);
    coef(1, 24'h000000, 24'h000000);
    dchk(24'h3fffff, 24'h000000);
    // checksum with each polynomial and the changed flag
    wreg(acr_pkg::A_MODE, 16'h0001);
    passes();
    rchk(acr_pkg::A_CHECKSUM, crc(acr_pkg::POLY_CCITT));
    u_host.rd(acr_pkg::A_STATUS, v);
    rchk(acr_pkg::A_STATUS, 16'h0000);
    wreg(acr_pkg::A_MODE, 16'h0003);
    passes();
    rchk(acr_pkg::A_CHECKSUM, crc(acr_pkg::POLY_ANSI));
    rchk(acr_pkg::A_STATUS, 16'h0001);
    rchk(acr_pkg::A_STATUS, 16'h0000);
    wreg(6'h04, 16'h0042);
    passes();
    e = crc(acr_pkg::POLY_ANSI);
    @(posedge clk) nul <= 1'b1;
    @(posedge clk) nul <= 1'b0;
    rchk(acr_pkg::A_STATUS, 16'h0000);
    wreg(acr_pkg::A_MODE, 16'h0000);
    wreg(6'h06, 16'h1111);
    passes();
    rchk(acr_pkg::A_CHECKSUM, e);
    rchk(acr_pkg::A_STATUS, 16'h0000);
    // reset by command, host rewrites the channel 0 coefficients
    @(posedge clk) cmd <= 1'b1;
    @(posedge clk) cmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ready low", 24'h000000, {23'h0, rdy_n});
    u_host.wait_ready(ok);
    reset_img();
    rchk(acr_pkg::A_MODE, acr_pkg::RST_MODE);
    rchk(6'h06, acr_pkg::RST_GAIN_HI);
    coef(0, 24'h100001, 24'h800000);
    dchk(24'h6ffffe, 24'h800000);
    // short pin pulse keeps state, long one resets and holds
    @(posedge clk) sync_n <= 1'b0;
    @(posedge clk) sync_n <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(6'h04, 16'h1000);
    @(posedge clk) sync_n <= 1'b0;
    repeat (40) @(posedge clk);
    chk("ready held", 24'h000000, {23'h0, rdy_n});
    sync_n <= 1'b1;
    repeat (6) @(posedge clk);
    u_host.wait_ready(ok);
    rchk(6'h04, acr_pkg::RST_OFS_HI);
    stop_test();
  end
endmodule
